/* File: pkg/ivm_pkg.sv */
`default_nettype none
package ivm_pkg;
  // vector address width and base register width
  localparam int unsigned VEC_W = 24;
  localparam int unsigned BASE_W = 15;
  localparam logic [BASE_W-1:0] BASE_RST = 15'h7fff;
  // fixed per-source offsets
  localparam logic [8:0] OFS_OPC1 = 9'h1f8;
  localparam logic [8:0] OFS_OPC2 = 9'h1f4;
  localparam logic [8:0] OFS_SWI_INSTR = 9'h1f0;
  localparam logic [8:0] OFS_SYSCALL = 9'h1ec;
  localparam logic [8:0] OFS_MACH = 9'h1e8;
  localparam logic [8:0] OFS_TCH0 = 9'h1cc;
  localparam logic [8:0] OFS_TCH_STEP = 9'h004;
  localparam logic [8:0] OFS_ACC_OVF = 9'h1a8;
  localparam logic [8:0] OFS_ACC_EDGE = 9'h1a4;
  localparam logic [8:0] OFS_SEQ_ABORT = 9'h188;
  localparam logic [8:0] OFS_BATT = 9'h140;
  // source count: 5 traps, 8 channels, 4 peripheral sources
  localparam int unsigned NSRC = 17;
  // delivery state machine
  typedef enum logic [1:0] {
    IVM_IDLE = 2'b00,
    IVM_REQ = 2'b01,
    IVM_WAIT = 2'b11
  } ivm_state_t;
endpackage : ivm_pkg
`default_nettype wire

/* File: logic/ivm_pend_bit.sv */
`default_nettype none
// one pending latch: set wins over clear
module ivm_pend_bit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // event and clear
  input wire logic i_set,
  input wire logic i_clr,
  // state
  output logic o_pend
);
  logic pend_r;
  logic pend_nxt;

  // a new event in the clear cycle stays pending
  always_comb begin
    pend_nxt = pend_r;
    if (i_clr) begin
      pend_nxt = 1'b0;
    end
    if (i_set) begin
      pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pend_r <= 1'b0;
    end else if (i_ce) begin
      pend_r <= pend_nxt;
    end
  end

  assign o_pend = pend_r;
endmodule : ivm_pend_bit
`default_nettype wire

/* File: logic/ivm_vector_map.sv */
`default_nettype none
module ivm_vector_map
  import ivm_pkg::*;
(
  // clock, enable, reset
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic i_rst_b,
  // base register write port
  input wire logic i_base_we,
  input wire logic [ivm_pkg::BASE_W-1:0] i_base_wdata,
  // trap and instruction events, one-cycle pulses
  input wire logic i_opc1_trap,
  input wire logic i_opc2_trap,
  input wire logic i_software_interrupt_instr,
  input wire logic i_system_call_instr,
  input wire logic i_mach_exc,
  // peripheral request events, one-cycle pulses
  input wire logic [7:0] i_tch_evt,
  input wire logic i_acc_ovf_evt,
  input wire logic i_acc_edge_evt,
  input wire logic i_seq_abort_evt,
  input wire logic i_batt_evt,
  // local enables
  input wire logic [7:0] i_channel_irq_enable,
  input wire logic i_accum_overflow_enable,
  input wire logic i_accum_edge_enable,
  input wire logic i_sequence_abort_enable,
  input wire logic i_battery_high_enable,
  input wire logic i_battery_low_enable,
  // global mask bit of condition_code_reg, and low-power state
  input wire logic i_imask,
  input wire logic i_in_wait,
  input wire logic i_in_stop,
  // core handshake
  input wire logic i_ack,
  output logic o_irq,
  output logic [ivm_pkg::VEC_W-1:0] o_vec_addr,
  output logic [ivm_pkg::BASE_W-1:0] o_vector_base_register,
  output logic o_wake
);
  import ivm_pkg::*;

  logic [BASE_W-1:0] base_r;
  logic [BASE_W-1:0] base_nxt;
  ivm_state_t st_r;
  ivm_state_t st_nxt;
  logic [4:0] sel_r;
  logic [4:0] sel_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [VEC_W-1:0] vec_r;
  logic [VEC_W-1:0] vec_nxt;
  logic wake_r;
  logic wake_nxt;
  logic [NSRC-1:0] set_v;
  logic [NSRC-1:0] clr_v;
  logic [NSRC-1:0] pend_v;
  logic [NSRC-1:0] ok_v;
  logic [NSRC-1:0] unmask_v;
  logic [8:0] ofs_tab [NSRC];
  logic any_ok;
  logic [4:0] win;
  logic wake_any;

  // source index 0 is the highest offset, indices follow vector order
  always_comb begin
    ofs_tab[0] = OFS_OPC1;
    ofs_tab[1] = OFS_OPC2;
    ofs_tab[2] = OFS_SWI_INSTR;
    ofs_tab[3] = OFS_SYSCALL;
    ofs_tab[4] = OFS_MACH;
    for (int k = 0; k < 8; k++) begin
      ofs_tab[5+k] = 9'(OFS_TCH0 - 9'(k) * OFS_TCH_STEP);
    end
    ofs_tab[13] = OFS_ACC_OVF;
    ofs_tab[14] = OFS_ACC_EDGE;
    ofs_tab[15] = OFS_SEQ_ABORT;
    ofs_tab[16] = OFS_BATT;
  end

  // events latch regardless of mask so none is lost while masked
  always_comb begin
    set_v = {i_batt_evt, i_seq_abort_evt, i_acc_edge_evt, i_acc_ovf_evt,
             i_tch_evt, i_mach_exc, i_system_call_instr,
             i_software_interrupt_instr, i_opc2_trap, i_opc1_trap};
    clr_v = '0;
    if (st_r == IVM_WAIT && i_ack) begin
      clr_v[sel_r] = 1'b1;
    end
  end

  // one pending latch per source
  for (genvar g = 0; g < NSRC; g++) begin : g_pend
    ivm_pend_bit u_pend (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_set(set_v[g]),
      .i_clr(clr_v[g]),
      .o_pend(pend_v[g])
    );
  end

  // enable and mask qualification per source
  always_comb begin
    unmask_v = '0;
    unmask_v[0] = 1'b1;
    unmask_v[1] = 1'b1;
    unmask_v[2] = 1'b1;
    unmask_v[3] = 1'b1;
    unmask_v[4] = 1'b1;
    for (int k = 0; k < 8; k++) begin
      unmask_v[5+k] = !i_imask && i_channel_irq_enable[k];
    end
    unmask_v[13] = !i_imask && i_accum_overflow_enable;
    unmask_v[14] = !i_imask && i_accum_edge_enable;
    unmask_v[15] = !i_imask && i_sequence_abort_enable;
    unmask_v[16] = !i_imask && (i_battery_high_enable || i_battery_low_enable);
    ok_v = pend_v & unmask_v;
  end

  // lowest index is highest offset, so it wins
  always_comb begin
    win = 5'h00;
    any_ok = |ok_v;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (ok_v[k]) begin
        win = 5'(k);
      end
    end
  end

  // wake: none of these sources may wake from stop, only from wait
  always_comb begin
    wake_any = |(pend_v[NSRC-1:5] & unmask_v[NSRC-1:5]);
    wake_nxt = i_in_wait && !i_in_stop && wake_any;
  end

  // base register, software writable
  always_comb begin
    base_nxt = base_r;
    if (i_base_we) begin
      base_nxt = i_base_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      base_r <= BASE_RST;
    end else if (i_ce) begin
      base_r <= base_nxt;
    end
  end

  // delivery: request held until ack or until the winner is masked again; winner frozen while waiting
  always_comb begin
    st_nxt = st_r;
    sel_nxt = sel_r;
    irq_nxt = irq_r;
    vec_nxt = vec_r;
    unique case (st_r)
      IVM_IDLE: begin
        if (any_ok) begin
          sel_nxt = win;
          vec_nxt = {base_r, ofs_tab[win]};
          irq_nxt = 1'b1;
          st_nxt = IVM_REQ;
        end
      end
      IVM_REQ: begin
        st_nxt = IVM_WAIT;
      end
      IVM_WAIT: begin
        if (i_ack) begin
          irq_nxt = 1'b0;
          st_nxt = IVM_IDLE;
        end else if (!ok_v[sel_r]) begin
          // masked again before the core took it: withdraw, keep pending
          irq_nxt = 1'b0;
          st_nxt = IVM_IDLE;
        end
      end
      default: begin
        st_nxt = IVM_IDLE;
        irq_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_r <= IVM_IDLE;
      sel_r <= 5'h00;
      irq_r <= 1'b0;
      vec_r <= '0;
      wake_r <= 1'b0;
    end else if (i_ce) begin
      st_r <= st_nxt;
      sel_r <= sel_nxt;
      irq_r <= irq_nxt;
      vec_r <= vec_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign o_irq = irq_r;
  assign o_vec_addr = vec_r;
  assign o_vector_base_register = base_r;
  assign o_wake = wake_r;
endmodule : ivm_vector_map
`default_nettype wire

/* File: sim/ivm_vector_map_monitor.sv */
`default_nettype none
module ivm_vector_map_monitor
  import ivm_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // watched inputs
  input wire logic i_imask,
  input wire logic i_in_wait,
  input wire logic i_in_stop,
  input wire logic i_ack,
  input wire logic i_opc1_trap,
  // watched outputs
  input wire logic o_irq,
  input wire logic [ivm_pkg::VEC_W-1:0] o_vec_addr,
  input wire logic [ivm_pkg::BASE_W-1:0] o_vector_base_register,
  input wire logic o_wake
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // traps sit at 0x1e8 and up, every lower offset obeys the mask
  wire logic [8:0] ofs = o_vec_addr[8:0];
  wire logic trap = ofs >= 9'h1e8;
  a_masked_issue: assert property (o_irq && !trap |-> !$past(i_imask))
    else $error("masked source issued");
  a_base_plus_ofs: assert property (o_irq |-> o_vec_addr[23:9] == o_vector_base_register)
    else $error("vector off base");
  a_stop_no_wake: assert property (i_in_stop |=> !o_wake)
    else $error("wake in stop");
  a_wake_in_wait: assert property (o_wake |-> $past(i_in_wait))
    else $error("wake outside wait");
  a_wake_unmasked: assert property (o_wake |-> !$past(i_imask))
    else $error("wake while masked");
  a_trap_stands: assert property ($rose(o_irq) && trap |=> o_irq && $stable(o_vec_addr))
    else $error("trap vector dropped");
  a_ack_retires: assert property (o_irq && i_ack && !$rose(o_irq) |=> !o_irq)
    else $error("ack ignored");
  a_opc1_served: assert property (i_opc1_trap |-> ##[1:16] (o_irq && ofs == 9'h1f8))
    else $error("opcode trap lost");
endmodule // ivm_vector_map_monitor
bind ivm_vector_map ivm_vector_map_monitor u_mon (.*);
`default_nettype wire

/* File: sim/ivm_core_model.sv */
`default_nettype none
module ivm_core_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // vector request, fetch pace, accept
  input wire logic i_irq,
  input wire logic [3:0] i_dly,
  output logic o_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r;
  // one-cycle ack after the vector stood i_dly-1 cycles; never in its first cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !i_irq || o_ack) begin
      cnt_r <= 4'h0;
      o_ack <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      o_ack <= cnt_r + 4'h2 >= i_dly;
    end
  end
endmodule // ivm_core_model
`default_nettype wire

/* File: sim/interrupt_vector_map_tb.sv */
`default_nettype none
module interrupt_vector_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ivm_pkg::*;
  // ports, stimulus and reference state
  logic i_clk = 0, i_rst_b = 0, i_ce = 1, i_base_we = 0, i_imask = 0, i_in_wait = 0;
  logic i_in_stop = 0, i_battery_high_enable = 0, i_battery_low_enable = 0;
  logic i_opc1_trap, i_opc2_trap, i_software_interrupt_instr, i_system_call_instr, i_mach_exc;
  logic i_acc_ovf_evt, i_acc_edge_evt, i_seq_abort_evt, i_batt_evt, i_ack, o_irq, o_wake;
  logic i_accum_overflow_enable, i_accum_edge_enable, i_sequence_abort_enable;
  logic [7:0] i_tch_evt, i_channel_irq_enable;
  logic [BASE_W-1:0] i_base_wdata = 15'h0, o_vector_base_register, base_x;
  logic [VEC_W-1:0] o_vec_addr;
  logic [16:0] ev = 17'h0, pm;
  logic [10:0] en_l = 11'h0;
  logic [3:0] dly = 4'h2;
  logic wq, wexp = 1'b0;
  integer seed = 32'h6d28, error_cnt = 0, total_checks = 0, cyc = 0, w;
  // offsets in priority order: traps, channels 0..7, accumulator, abort, battery
  logic [8:0] ofs_t [17] = '{9'h1f8, 9'h1f4, 9'h1f0, 9'h1ec, 9'h1e8, 9'h1cc, 9'h1c8, 9'h1c4,
    9'h1c0, 9'h1bc, 9'h1b8, 9'h1b4, 9'h1b0, 9'h1a8, 9'h1a4, 9'h188, 9'h140};
  assign {i_batt_evt, i_seq_abort_evt, i_acc_edge_evt, i_acc_ovf_evt, i_tch_evt, i_mach_exc,
    i_system_call_instr, i_software_interrupt_instr, i_opc2_trap, i_opc1_trap} = ev;
  assign {i_sequence_abort_enable, i_accum_edge_enable, i_accum_overflow_enable,
    i_channel_irq_enable} = en_l;
  ivm_vector_map i_ivm_vector_map (.*);
  ivm_core_model i_ivm_core_model (.i_clk, .i_rst_b, .i_irq(o_irq), .i_dly(dly), .o_ack(i_ack));
  initial forever #50 i_clk = ~i_clk;
  task chk(input logic [VEC_W-1:0] got, input logic [VEC_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_wake(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t wake got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test();
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // reference: the qualified pending source with the highest offset wins each grant
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      end_of_test();
    end
    pm <= i_rst_b ? pm | ev : 17'h0;
    // wake stands one edge after a qualified maskable source is pending in wait
    if (cyc > 1) chk_wake(o_wake, wexp);
    wq = 1'b0;
    for (int k = 16; k >= 5; k--)
      if (pm[k] && !i_imask && (k == 16 ?
          i_battery_high_enable | i_battery_low_enable : en_l[k - 5])) wq = 1'b1;
    wexp = i_rst_b && i_in_wait && !i_in_stop && wq;
    if (o_irq === 1'b1 && i_ack === 1'b1) begin
      w = 99;
      for (int k = 16; k >= 0; k--)
        if (pm[k] && (k < 5 || !i_imask && (k == 16 ?
            i_battery_high_enable | i_battery_low_enable : en_l[k - 5]))) w = k;
      chk(o_vec_addr, {base_x, ofs_t[w]});
      pm[w] <= 1'b0;
    end
  end
  // each pass: reset, relocate, burst of events, then unmask, then enable all
  initial begin
    repeat (2) @(posedge i_clk);
    for (int s = 0; s < 16; s++) begin
      i_rst_b <= 1'b1;
      @(posedge i_clk);
      chk(o_vector_base_register, 15'h7fff);
      i_base_we <= 1'b1;
      i_base_wdata <= 15'($random(seed));
      i_imask <= s[0];
      i_in_wait <= s[1];
      i_in_stop <= s[2];
      {i_battery_high_enable, i_battery_low_enable, en_l} <= 13'($random(seed));
      dly <= 4'(2 + s % 8);
      @(posedge i_clk);
      i_base_we <= 1'b0;
      base_x = i_base_wdata;
      ev <= 17'($random(seed));
      @(posedge i_clk);
      ev <= 17'h0;
      repeat (250) @(posedge i_clk);
      i_imask <= 1'b0;
      repeat (250) @(posedge i_clk);
      en_l <= 11'h7ff;
      i_battery_low_enable <= 1'b1;
      repeat (250) @(posedge i_clk);
      chk(o_vector_base_register, base_x);
      chk(pm, 0);
      i_rst_b <= 1'b0;
      @(posedge i_clk);
    end
    end_of_test();
  end
endmodule // interrupt_vector_map_tb
`default_nettype wire
